//--- pkg/clockgen_pkg.sv
// Purpose: Shared constants for the clock generator control block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: Offsets are byte addresses
package clockgen_pkg;
    localparam logic [3:0] pll_control_offset = 4'h0;
    localparam logic [3:0] bandwidth_control_offset = 4'h4;
    localparam logic [3:0] break_flag_control_offset = 4'h8;
    localparam logic [3:0] run_control_offset = 4'hC;
    // pll_control_register fields
    localparam int irq_enable_bit = 7;
    localparam int flag_bit = 6;
    localparam int power_on_bit = 5;
    localparam int select_bit = 4;
    localparam logic [3:0] pll_control_low_ones = 4'hF;
    // bandwidth_control_register fields
    localparam int auto_bit = 7;
    localparam int lock_bit = 6;
    localparam int tracking_bit = 5;
    // break_flag_control_register field
    localparam int break_clear_bit = 7;
    // run_control fields
    localparam int stop_bit = 0;
    localparam int break_bit = 1;
    // Reset values, then bus response codes
    localparam logic reset_power_on = 1'b1;
    localparam logic reset_select = 1'b0;
    localparam logic reset_auto = 1'b0;
    localparam logic reset_break_clear = 1'b0;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
endpackage

//--- src/clock_divider.sv
// Purpose: Halves a clock as a one-cycle enable pulse stream
// Assumes: Single mclk domain, source given as an enable
// Notes: Held clear while idle so restart is deterministic
`timescale 1ns/1ps
`default_nettype none
module clock_divider (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic src_tick,
    output logic half_tick
);
    logic phase;
    logic next_phase;
    logic next_half_tick;

    always_comb begin
        next_phase = phase;
        next_half_tick = 1'b0;
        if (!run) begin
            next_phase = 1'b0;
        end else if (src_tick) begin
            next_phase = ~phase;
            next_half_tick = phase;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 1'b0;
            half_tick <= 1'b0;
        end else begin
            phase <= next_phase;
            half_tick <= next_half_tick;
        end
    end
endmodule
`default_nettype wire

//--- src/pll_lock_event_and_power_mode_control.sv
// Purpose: Lock-change flag, interrupt, base clock select and low-power handling of a PLL
// Assumes: AXI4-Lite slave on mclk; crystal and VCO ticks arrive as enables; lock from analog loop
// Notes: Base clock is an enable pulse at half the selected source rate
// Behaviour
// [R01] Auto mode: every lock indicator change raises a PLL interrupt request.
// [R02] Interrupt enable bit gates the lock-change flag onto the interrupt.
// [R03] Lock-change flag sets on every change, enabled or not.
// [R04] Auto off: no interrupt and the flag reads 0.
// [R05] Software reads lock after an interrupt to learn entry or exit.
// [R06] Select bit may pick VCO clock even while unlocked.
// [R07] Software confirms lock before selecting the VCO clock.
// [R08] Clock generator keeps running in wait mode.
// [R09] Software may deselect or power down the loop before wait.
// [R10] Stop holds crystal clock, base clock and interrupt outputs low.
// [R11] Stop clears the select bit, returning to the crystal clock.
// [R12] After stop, base clock is crystal halved; select stays clear.
// [R13] Software sets break clear-enable to permit clearing during break.
// [R14] A flag cleared during break stays cleared after break.
// [R15] Clear-enable 0: control register accesses in break keep the flag.
// [R16] Auto mode: tracking bit sets when acquisition ends.
// [R17] Auto mode: lock bit sets when lock time ends.
// [R18] Any control register read clears the flag; reset clears it too. Here only a PLL control register read clears it.
// [R19] Power-on cannot clear while select set; select cannot set while off.
// [R20] Interrupt stays high while flag and enable are 1.
`timescale 1ns/1ps
`default_nettype none
module pll_lock_event_and_power_mode_control (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic crystal_tick,
    input wire logic vco_tick,
    input wire logic loop_locked,
    input wire logic loop_tracking,
    output logic crystal_clock,
    output logic base_clock_out,
    output logic clockgen_irq_out,
    output logic loop_power_on
);
    // Loop status comes from the analog domain: two flops each
    logic lock_meta, lock_sync, track_meta, track_sync, lock_prev;
    logic next_lock_prev;

    logic lock_change_flag, lock_change_irq_enable, base_clock_select, auto_mode;
    logic break_clear_enable, stop_mode, break_mode;
    logic next_flag, next_irq_enable, next_power_on, next_select, next_auto;
    logic next_break_clear, next_stop, next_break;

    logic aw_held, w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held, next_w_held;
    logic [3:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;

    logic next_crystal_clock, next_base_clock, next_irq;
    logic half_tick, src_tick, wr_fire, rd_fire, lock_event, flag_clear;

    function automatic logic lane_bit(input logic [31:0] d, input logic [3:0] s,
                                      input int b, input logic old);
        lane_bit = s[b / 8] ? d[b] : old;
    endfunction

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lock_meta <= 1'b0;
            lock_sync <= 1'b0;
            track_meta <= 1'b0;
            track_sync <= 1'b0;
        end else begin
            lock_meta <= loop_locked;
            lock_sync <= lock_meta;
            track_meta <= loop_tracking;
            track_sync <= track_meta;
        end
    end

    // Base clock source; VCO only while the loop is powered
    assign src_tick = (base_clock_select && loop_power_on) ? vco_tick : crystal_tick;

    clock_divider u_base_div (
        .mclk(mclk),
        .rst_n(rst_n),
        .run(!stop_mode),
        .src_tick(src_tick),
        .half_tick(half_tick)
    );

    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    // Lock edges only count in auto mode
    assign lock_event = auto_mode && (lock_sync != lock_prev); // R01
    // A PLL control register read clears the flag unless break protects it
    assign flag_clear = rd_fire && (s_axi_araddr == clockgen_pkg::pll_control_offset)
                        && (!break_mode || break_clear_enable); // R18 R15 R14

    always_comb begin
        next_lock_prev = lock_sync;
        next_flag = lock_change_flag;
        next_irq_enable = lock_change_irq_enable;
        next_power_on = loop_power_on;
        next_select = base_clock_select;
        next_auto = auto_mode;
        next_break_clear = break_clear_enable;
        next_stop = stop_mode;
        next_break = break_mode;
        next_bresp = s_axi_bresp;
        if (flag_clear) begin
            next_flag = 1'b0; // R18
        end
        if (lock_event) begin
            next_flag = 1'b1; // R03 R01
        end
        if (!auto_mode) begin
            next_flag = 1'b0; // R04
            next_irq_enable = 1'b0;
        end
        if (wr_fire) begin
            next_bresp = clockgen_pkg::resp_okay;
            unique case (aw_addr)
                clockgen_pkg::pll_control_offset: begin
                    if (auto_mode) begin
                        next_irq_enable = lane_bit(w_data, w_strb, clockgen_pkg::irq_enable_bit,
                                                   lock_change_irq_enable);
                    end
                    // Select protects power, power gates select; lock is not checked
                    next_power_on = lane_bit(w_data, w_strb, clockgen_pkg::power_on_bit,
                                             loop_power_on) || base_clock_select; // R19
                    next_select = lane_bit(w_data, w_strb, clockgen_pkg::select_bit,
                                           base_clock_select) && loop_power_on; // R19 R06
                end
                clockgen_pkg::bandwidth_control_offset: begin
                    next_auto = lane_bit(w_data, w_strb, clockgen_pkg::auto_bit, auto_mode);
                end
                clockgen_pkg::break_flag_control_offset: begin
                    next_break_clear = lane_bit(w_data, w_strb, clockgen_pkg::break_clear_bit,
                                                break_clear_enable);
                end
                clockgen_pkg::run_control_offset: begin
                    next_stop = lane_bit(w_data, w_strb, clockgen_pkg::stop_bit, stop_mode);
                    next_break = lane_bit(w_data, w_strb, clockgen_pkg::break_bit, break_mode);
                end
                default: begin
                    next_bresp = clockgen_pkg::resp_slverr;
                end
            endcase
        end
        // Entering stop drops back to the crystal; select stays clear after
        if (next_stop) begin
            next_select = 1'b0; // R11 R12
        end
    end

    // Bus channel state
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (rd_fire) begin
            next_rvalid = 1'b1;
            next_rresp = clockgen_pkg::resp_okay;
            next_rdata = 32'h0;
            unique case (s_axi_araddr)
                clockgen_pkg::pll_control_offset: begin
                    next_rdata[clockgen_pkg::irq_enable_bit] = lock_change_irq_enable;
                    next_rdata[clockgen_pkg::flag_bit] = lock_change_flag && auto_mode; // R04
                    next_rdata[clockgen_pkg::power_on_bit] = loop_power_on;
                    next_rdata[clockgen_pkg::select_bit] = base_clock_select;
                    next_rdata[3:0] = clockgen_pkg::pll_control_low_ones;
                end
                clockgen_pkg::bandwidth_control_offset: begin
                    next_rdata[clockgen_pkg::auto_bit] = auto_mode;
                    next_rdata[clockgen_pkg::lock_bit] = auto_mode && lock_sync; // R17
                    next_rdata[clockgen_pkg::tracking_bit] = auto_mode && track_sync; // R16
                end
                clockgen_pkg::break_flag_control_offset: begin
                    next_rdata[clockgen_pkg::break_clear_bit] = break_clear_enable;
                end
                clockgen_pkg::run_control_offset: begin
                    next_rdata[clockgen_pkg::stop_bit] = stop_mode;
                    next_rdata[clockgen_pkg::break_bit] = break_mode;
                end
                default: begin
                    next_rresp = clockgen_pkg::resp_slverr;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    // Outputs; wait needs no term, the generator simply keeps running
    always_comb begin
        next_crystal_clock = crystal_tick && !stop_mode; // R10 R08
        next_base_clock = half_tick && !stop_mode; // R10 R12
        next_irq = next_flag && next_irq_enable && next_auto && !next_stop; // R02 R20 R10 R04
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lock_prev <= 1'b0;
            lock_change_flag <= 1'b0; // R18
            lock_change_irq_enable <= 1'b0;
            loop_power_on <= clockgen_pkg::reset_power_on;
            base_clock_select <= clockgen_pkg::reset_select;
            auto_mode <= clockgen_pkg::reset_auto;
            break_clear_enable <= clockgen_pkg::reset_break_clear;
            stop_mode <= 1'b0;
            break_mode <= 1'b0;
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
            w_held <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= clockgen_pkg::resp_okay;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= clockgen_pkg::resp_okay;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            crystal_clock <= 1'b0;
            base_clock_out <= 1'b0;
            clockgen_irq_out <= 1'b0;
        end else begin
            lock_prev <= next_lock_prev;
            lock_change_flag <= next_flag;
            lock_change_irq_enable <= next_irq_enable;
            loop_power_on <= next_power_on;
            base_clock_select <= next_select;
            auto_mode <= next_auto;
            break_clear_enable <= next_break_clear;
            stop_mode <= next_stop;
            break_mode <= next_break;
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            s_axi_awready <= !next_aw_held;
            s_axi_wready <= !next_w_held;
            s_axi_arready <= !next_rvalid;
            crystal_clock <= next_crystal_clock;
            base_clock_out <= next_base_clock;
            clockgen_irq_out <= next_irq;
        end
    end
endmodule
`default_nettype wire

//--- verif/clockgen_monitor.sv
// Purpose: Port checker for the clock generator control block
// Assumes: Lane 0 always written; mode shadows trail the design by one edge
// Notes: Stop, break and auto are shadowed from completed writes
`timescale 1ns/1ps
`default_nettype none
module clockgen_monitor (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic loop_locked,
    input wire logic crystal_tick,
    input wire logic crystal_clock,
    input wire logic base_clock_out,
    input wire logic clockgen_irq_out
);
    logic [3:0] wa;
    logic [7:0] wd;
    logic bv_q, ar0, stp, brk, bce, aut, selz, upd;
    logic [3:0] lk_age, wr_age;
    assign upd = s_axi_bvalid && !bv_q && s_axi_bresp == clockgen_pkg::resp_okay;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {wa, wd, bv_q, ar0, stp, brk, bce, aut} <= '0;
            selz <= 1'b1;
            {lk_age, wr_age} <= 8'hFF;
        end else begin
            bv_q <= s_axi_bvalid;
            if (s_axi_awvalid) wa <= s_axi_awaddr;
            if (s_axi_wvalid) wd <= s_axi_wdata[7:0];
            if (s_axi_arvalid) ar0 <= s_axi_araddr == clockgen_pkg::pll_control_offset;
            lk_age <= $changed(loop_locked) ? 4'h0 : lk_age + {3'h0, lk_age != 4'hF};
            wr_age <= upd ? 4'h0 : wr_age + {3'h0, wr_age != 4'hF};
            if (upd && wa == clockgen_pkg::run_control_offset) {brk, stp} <= wd[1:0];
            if (upd && wa == clockgen_pkg::break_flag_control_offset) bce <= wd[7];
            if (upd && wa == clockgen_pkg::bandwidth_control_offset) aut <= wd[7];
            if (upd && wa == clockgen_pkg::pll_control_offset && wd[4]) selz <= 1'b0;
            // Stop forces select clear, so the shadow re-arms here
            if (stp) selz <= 1'b1;
        end
    end
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    xtal_copy_a: assert property (crystal_clock |-> $past(crystal_tick))
        else $error("crystal out without tick");
    base_gap_a: assert property (base_clock_out |=> !base_clock_out)
        else $error("base pulses back to back");
    irq_cause_a: assert property ($rose(clockgen_irq_out) |-> lk_age < 4'h8 || wr_age < 4'h8)
        else $error("irq rose without cause");
    stop_quiet_a: assert property (stp |-> !crystal_clock && !base_clock_out && !clockgen_irq_out)
        else $error("output active in stop");
    sel_clear_a: assert property (s_axi_rvalid && ar0 && selz |-> !s_axi_rdata[4])
        else $error("select set after stop");
    read_clear_a: assert property ($rose(s_axi_rvalid) && ar0 && $past(clockgen_irq_out)
        && (!brk || bce) && lk_age > 4'h5 |-> ##[0:2] !clockgen_irq_out)
        else $error("read kept irq");
    brk_keep_a: assert property ($rose(s_axi_rvalid) && ar0 && clockgen_irq_out
        && brk && !bce |-> clockgen_irq_out [*4])
        else $error("break read cleared flag");
    auto_gate_a: assert property (!aut |-> !clockgen_irq_out)
        else $error("irq in manual mode");
    cover property ($rose(clockgen_irq_out));
    cover property (stp ##1 !stp);
    cover property (brk && s_axi_rvalid && ar0);
endmodule
`default_nettype wire

//--- verif/loop_model.sv
// Purpose: Oscillator and analog loop stand-in
// Assumes: Ticks are mclk enables; lock follows the request after settling
// Notes: Tracking reports before lock, as acquisition ends first
`timescale 1ns/1ps
`default_nettype none
module loop_model #(
    parameter int settle = 3
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic lock_req,
    output logic crystal_tick,
    output logic vco_tick,
    output logic loop_locked,
    output logic loop_tracking
);
    logic [1:0] ph;
    int cnt;
    assign crystal_tick = ph == 2'h0;
    assign vco_tick = ph[0];
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ph <= 2'h0;
            cnt <= 0;
            loop_locked <= 1'b0;
            loop_tracking <= 1'b0;
        end else begin
            ph <= ph + 2'h1;
            cnt <= (lock_req == loop_locked) ? 0 : cnt + 1;
            if (cnt == 1) loop_tracking <= lock_req;
            if (cnt == settle) loop_locked <= lock_req;
        end
    end
endmodule
`default_nettype wire

//--- verif/pll_lock_event_and_power_mode_control_bench.sv
// Purpose: Self-checking bench for the clock generator control block
// Assumes: Loop model gives ticks and lock; the bench acts as software
// Notes: Fields sit on lane 0, so rdata[7:0] is compared
`timescale 1ns/1ps
`default_nettype none
module pll_lock_event_and_power_mode_control_bench;
    logic mclk = 1'b0, rst_n = 1'b0, lock_req = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rv;
    logic crystal_tick, vco_tick, loop_locked, loop_tracking;
    logic crystal_clock, base_clock_out, clockgen_irq_out, loop_power_on;
    int error_cnt = 0, compares = 0, base_n = 0, xtal_n = 0;
    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        base_n <= base_n + int'(base_clock_out);
        xtal_n <= xtal_n + int'(crystal_clock);
    end
    pll_lock_event_and_power_mode_control uut (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .crystal_tick, .vco_tick,
        .loop_locked, .loop_tracking, .crystal_clock, .base_clock_out, .clockgen_irq_out,
        .loop_power_on);
    loop_model lm (.mclk, .rst_n, .lock_req, .crystal_tick, .vco_tick, .loop_locked,
        .loop_tracking);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge mclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        check("write done", n < 50, 32'h1);
    endtask
    task automatic rd(input logic [3:0] a);
        int n;
        n = 0;
        @(posedge mclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge mclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        rv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        check("read done", n < 50, 32'h1);
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] e);
        rd(a);
        check($sformatf("reg %h", a), {24'h0, rv[7:0]}, {24'h0, e});
    endtask
    task automatic irq_is(input logic e);
        @(posedge mclk);
        check("irq", {31'h0, clockgen_irq_out}, {31'h0, e});
    endtask
    task automatic lockset(input logic l);
        @(posedge mclk);
        lock_req <= l;
        repeat (12) @(posedge mclk);
    endtask
    // One pulse of slack, as the window may cut a divider phase
    task automatic rate(input int eb, input int ex);
        int b0, x0;
        b0 = base_n;
        x0 = xtal_n;
        repeat (80) @(posedge mclk);
        // Slack of one pulse only when pulses are expected; none means exactly none
        check("base rate", 32'(base_n - b0 <= eb + 1 && base_n - b0 + 1 >= eb
            && (eb > 0 || base_n == b0)), 32'h1);
        check("crystal rate", 32'(xtal_n - x0 <= ex + 1 && xtal_n - x0 + 1 >= ex
            && (ex > 0 || xtal_n == x0)), 32'h1);
    endtask
    task automatic report_and_stop;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        rc(4'h0, 8'h2F);
        rc(4'h4, 8'h00);
        rd(4'h2);
        check("resp", {30'h0, rsp}, {30'h0, clockgen_pkg::resp_slverr});
        wr(4'h0, 8'hA0);
        lockset(1'b1);
        rc(4'h0, 8'h2F);
        irq_is(1'b0);
        lockset(1'b0);
        wr(4'h0, 8'h30);
        rc(4'h0, 8'h3F);
        wr(4'h0, 8'h10);
        rc(4'h0, 8'h3F);
        rate(20, 20);
        wr(4'h0, 8'h20);
        wr(4'h0, 8'h00);
        rc(4'h0, 8'h0F);
        check("power", {31'h0, loop_power_on}, 32'h0);
        wr(4'h0, 8'h10);
        rc(4'h0, 8'h0F);
        wr(4'h0, 8'h20);
        wr(4'h4, 8'h80);
        wr(4'h0, 8'hA0);
        lockset(1'b1);
        irq_is(1'b1);
        repeat (10) @(posedge mclk);
        irq_is(1'b1);
        rc(4'h4, 8'hE0);
        rc(4'h0, 8'hEF);
        irq_is(1'b0);
        rc(4'h0, 8'hAF);
        lockset(1'b0);
        irq_is(1'b1);
        rc(4'h4, 8'h80);
        rc(4'h0, 8'hEF);
        wr(4'h0, 8'h20);
        lockset(1'b1);
        irq_is(1'b0);
        rc(4'h0, 8'h6F);
        wr(4'hC, 8'h02);
        wr(4'h0, 8'hA0);
        lockset(1'b0);
        rc(4'h0, 8'hEF);
        wr(4'h0, 8'hA0);
        rc(4'h0, 8'hEF);
        irq_is(1'b1);
        wr(4'h8, 8'h80);
        rc(4'h0, 8'hEF);
        wr(4'hC, 8'h00);
        rc(4'h0, 8'hAF);
        lockset(1'b1);
        wr(4'h0, 8'hB0);
        rc(4'h0, 8'hFF);
        lockset(1'b0);
        irq_is(1'b1);
        wr(4'hC, 8'h01);
        irq_is(1'b0);
        rate(0, 0);
        rc(4'h0, 8'hEF);
        wr(4'hC, 8'h00);
        rc(4'h0, 8'hAF);
        rate(10, 20);
        wr(4'h4, 8'h00);
        rc(4'h0, 8'h2F);
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        report_and_stop;
    end
endmodule
bind pll_lock_event_and_power_mode_control clockgen_monitor mon (.mclk, .rst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_wdata, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bresp, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_rdata, .s_axi_rvalid, .loop_locked, .crystal_tick, .crystal_clock,
    .base_clock_out, .clockgen_irq_out);
`default_nettype wire
